// [hdl/lpm_defines.svh]
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
`define LPM_CLK_HZ 50000000
`define LPM_FLOSS_MS 2500
`define LPM_FLCLR_MS 1000
`define LPM_OVH_KBPS 8'h08
`define LPM_HOUR_SECS 12'hE10
`define LPM_QTR_SECS 12'h384
`define LPM_HOURS 24
`define LPM_NCTR 6
`define LPM_UNAV_RUN 4'hA
`define LPM_THR_RST 16'h0040
`define LPM_A_CTRL 12'h000
`define LPM_A_CLEAR 12'h004
`define LPM_A_STATE 12'h008
`define LPM_A_QSTAT 12'h00C
`define LPM_A_THRESH 12'h010
`define LPM_A_SECS 12'h014
`define LPM_A_STATS 2'h1
`define LPM_CTRL_PERF 0
`define LPM_CTRL_SEL 1
`define LPM_QS_E 0
`define LPM_QS_L 1
`define LPM_QS_T 2
`endif

// [hdl/lpm_monitor.sv]
`timescale 1ns/1ns
`include "lpm_defines.svh"
// How it works
// - Monitoring mode reserves 8 kbps overhead; normal mode reserves nothing.
// - Statistics are valid only when both ends run monitoring mode.
// - Each hour is split into 3600 one-second slots feeding the hour's counters.
// - Current hour plus 24 past hours of counters stay readable.
// - A second with any checksum-failed frame counts as errored.
// - A second whose bit errors exceed the threshold counts as severe.
// - A second with errors not above the threshold counts as bursty.
// - Ten consecutive severe seconds enter the outage state.
// - Ten consecutive non-severe seconds leave the outage state.
// - Every second inside the outage state adds one outage second.
// - Sync loss or misframing held 2.5 s declares frame loss.
// - One clean second clears a declared frame loss.
// - Frame loss count grows once per declaration.
// - Seconds without remote data are counted in the local set only.
// - Each quarter hour records a status code when conditions occurred.
// - Status codes mark test loopback, sync loss and excessive errors.
// - Local and remote sets are kept apart and read separately.
// - Clear zeroes only the selected set.
module lpm_monitor #(
  parameter int unsigned SEC_CYCLES = `LPM_CLK_HZ,
  parameter int unsigned FLOSS_CYCLES = `LPM_CLK_HZ / 1000 * `LPM_FLOSS_MS,
  parameter int unsigned FLCLR_CYCLES = `LPM_CLK_HZ / 1000 * `LPM_FLCLR_MS,
  parameter int unsigned CW = 12
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [1:0] crc_err_in,
  input wire logic [1:0] bit_err_in,
  input wire logic [1:0] sync_loss_in,
  input wire logic [1:0] out_of_framing_in,
  input wire logic loopback_in,
  input wire logic remote_data_in,
  output logic [7:0] ovh_kbps_out,
  output logic [1:0] frame_loss_state_out,
  output logic [1:0] outage_out,
  output logic sec_tick_out
);
  localparam int unsigned NH = `LPM_HOURS + 1;
  localparam int unsigned NC = `LPM_NCTR;

  // ==========================================================
  // Register port
  logic [1:0] ctrl_r;
  logic [15:0] thresh_r;
  logic clr_req;
  logic [1:0] clr_set;
  always_comb begin
    clr_req = wr_in && (addr_in == `LPM_A_CLEAR) && wdata_in[0];
    clr_set[0] = clr_req && !ctrl_r[`LPM_CTRL_SEL];
    clr_set[1] = clr_req && ctrl_r[`LPM_CTRL_SEL];
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_r <= 2'h0;
      thresh_r <= `LPM_THR_RST;
    end else if (wr_in && addr_in == `LPM_A_CTRL) begin
      ctrl_r <= wdata_in[1:0];
    end else if (wr_in && addr_in == `LPM_A_THRESH) begin
      thresh_r <= wdata_in[15:0];
    end
  end

  // The remote set is only meaningful when the far card also runs monitoring.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ovh_kbps_out <= 8'h00;
    end else begin
      ovh_kbps_out <= ctrl_r[`LPM_CTRL_PERF] ? `LPM_OVH_KBPS : 8'h00;
    end
  end

  // ==========================================================
  // Second and hour time base
  logic [31:0] div_r;
  logic [11:0] slot_r;
  logic tick;
  logic hour_end;
  logic [1:0] qidx;
  always_comb begin
    tick = (div_r == SEC_CYCLES - 1);
    hour_end = tick && (slot_r == `LPM_HOUR_SECS - 12'h001);
    if (slot_r >= 3 * `LPM_QTR_SECS) qidx = 2'h3;
    else if (slot_r >= 2 * `LPM_QTR_SECS) qidx = 2'h2;
    else if (slot_r >= `LPM_QTR_SECS) qidx = 2'h1;
    else qidx = 2'h0;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      div_r <= 32'h0;
      slot_r <= 12'h000;
      sec_tick_out <= 1'b0;
    end else begin
      sec_tick_out <= tick;
      div_r <= tick ? 32'h0 : div_r + 32'h1;
      if (hour_end) slot_r <= 12'h000;
      else if (tick) slot_r <= slot_r + 12'h001;
    end
  end

  // ==========================================================
  // Per-second tallies; an event on the tick cycle joins the closing second.
  logic [1:0] crc_seen_r;
  logic [1:0] sync_seen_r;
  logic rdat_seen_r;
  logic [15:0] berr_r [2];
  logic [15:0] berr_now [2];
  logic [1:0] sev_now;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      berr_now[s] = berr_r[s] + {15'h0, bit_err_in[s]};
      if (berr_r[s] == 16'hFFFF) berr_now[s] = berr_r[s];
      sev_now[s] = berr_now[s] > thresh_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      crc_seen_r <= 2'h0;
      sync_seen_r <= 2'h0;
      rdat_seen_r <= 1'b0;
      berr_r[0] <= 16'h0;
      berr_r[1] <= 16'h0;
    end else begin
      rdat_seen_r <= !tick && (rdat_seen_r || remote_data_in);
      for (int s = 0; s < 2; s++) begin
        crc_seen_r[s] <= !tick && (crc_seen_r[s] || crc_err_in[s]);
        sync_seen_r[s] <= !tick && (sync_seen_r[s] || sync_loss_in[s]);
        berr_r[s] <= tick ? 16'h0 : berr_now[s];
      end
    end
  end

  // ==========================================================
  // Outage state, counted in runs of ten seconds
  lpm_pkg::lpm_av_e av_r [2];
  logic [3:0] run_r [2];
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int s = 0; s < 2; s++) begin
        av_r[s] <= lpm_pkg::LPM_AVAIL;
        run_r[s] <= 4'h0;
      end
      outage_out <= 2'h0;
    end else if (tick) begin
      for (int s = 0; s < 2; s++) begin
        case (av_r[s])
          lpm_pkg::LPM_AVAIL: begin
            if (!sev_now[s]) begin
              run_r[s] <= 4'h0;
            end else if (run_r[s] == `LPM_UNAV_RUN - 4'h1) begin
              av_r[s] <= lpm_pkg::LPM_OUTAGE;
              outage_out[s] <= 1'b1;
              run_r[s] <= 4'h0;
            end else begin
              run_r[s] <= run_r[s] + 4'h1;
            end
          end
          lpm_pkg::LPM_OUTAGE: begin
            if (sev_now[s]) begin
              run_r[s] <= 4'h0;
            end else if (run_r[s] == `LPM_UNAV_RUN - 4'h1) begin
              av_r[s] <= lpm_pkg::LPM_AVAIL;
              outage_out[s] <= 1'b0;
              run_r[s] <= 4'h0;
            end else begin
              run_r[s] <= run_r[s] + 4'h1;
            end
          end
          default: begin
            av_r[s] <= lpm_pkg::LPM_AVAIL;
            run_r[s] <= 4'h0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Frame loss, timed in clock cycles rather than ticks for the 2.5 s figure
  logic [31:0] floss_cnt_r [2];
  logic [1:0] flc_pend_r;
  logic [1:0] bad;
  logic [1:0] floss_decl;
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      bad[s] = sync_loss_in[s] || out_of_framing_in[s];
      floss_decl[s] = bad[s] && !frame_loss_state_out[s]
        && (floss_cnt_r[s] == FLOSS_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      floss_cnt_r[0] <= 32'h0;
      floss_cnt_r[1] <= 32'h0;
      frame_loss_state_out <= 2'h0;
      flc_pend_r <= 2'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        // A declaration on the tick cycle is counted directly, so the pend is dropped.
        flc_pend_r[s] <= !tick && (flc_pend_r[s] || floss_decl[s]);
        if (bad[s] == frame_loss_state_out[s]) begin
          floss_cnt_r[s] <= 32'h0;
        end else if (floss_decl[s]) begin
          frame_loss_state_out[s] <= 1'b1;
          floss_cnt_r[s] <= 32'h0;
        end else if (!bad[s] && floss_cnt_r[s] == FLCLR_CYCLES - 1) begin
          frame_loss_state_out[s] <= 1'b0;
          floss_cnt_r[s] <= 32'h0;
        end else begin
          floss_cnt_r[s] <= floss_cnt_r[s] + 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // Statistic sets: entry 0 is the current hour, 1 to 24 the history
  logic [NC-1:0] inc [2];
  logic [CW-1:0] cnt_r [2][NH][NC];
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      inc[s] = '0;
      inc[s][lpm_pkg::LPM_C_ERR] = crc_seen_r[s] || crc_err_in[s];
      inc[s][lpm_pkg::LPM_C_SEV] = sev_now[s];
      inc[s][lpm_pkg::LPM_C_BURST] = (berr_now[s] != 16'h0) && !sev_now[s];
      inc[s][lpm_pkg::LPM_C_OUT] = (av_r[s] == lpm_pkg::LPM_OUTAGE);
      inc[s][lpm_pkg::LPM_C_FLC] = flc_pend_r[s] || floss_decl[s];
    end
    inc[0][lpm_pkg::LPM_C_RDA] = !(rdat_seen_r || remote_data_in);
  end

  // A clear on the tick cycle still keeps that second's increments.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int s = 0; s < 2; s++)
        for (int h = 0; h < NH; h++)
          for (int c = 0; c < NC; c++)
            cnt_r[s][h][c] <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        for (int h = 0; h < NH; h++) begin
          for (int c = 0; c < NC; c++) begin
            if (hour_end) begin
              if (h == 0 || clr_set[s]) cnt_r[s][h][c] <= '0;
              else cnt_r[s][h][c] <= cnt_r[s][(h == 0) ? 0 : h - 1][c];
              if (h == 1) cnt_r[s][h][c] <= (clr_set[s] ? '0 : cnt_r[s][0][c])
                + {{(CW-1){1'b0}}, inc[s][c]};
            end else if (clr_set[s]) begin
              cnt_r[s][h][c] <= '0;
              if (h == 0 && tick) cnt_r[s][h][c] <= {{(CW-1){1'b0}}, inc[s][c]};
            end else if (h == 0 && tick) begin
              cnt_r[s][h][c] <= cnt_r[s][h][c] + {{(CW-1){1'b0}}, inc[s][c]};
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Quarter-hour status codes of the current hour
  lpm_pkg::lpm_qcode_t qst_r [2][4];
  lpm_pkg::lpm_qcode_t qev [2];
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      qev[s] = '0;
      qev[s][`LPM_QS_T] = loopback_in;
      qev[s][`LPM_QS_L] = sync_seen_r[s] || sync_loss_in[s];
      qev[s][`LPM_QS_E] = sev_now[s];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int s = 0; s < 2; s++)
        for (int q = 0; q < 4; q++)
          qst_r[s][q] <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        for (int q = 0; q < 4; q++) begin
          if (hour_end || clr_set[s]) qst_r[s][q] <= '0;
          else if (tick && qidx == q) qst_r[s][q] <= qst_r[s][q] | qev[s];
        end
      end
    end
  end

  // ==========================================================
  // Read data stand for exactly the cycle after the read strobe.
  logic sel;
  logic [7:0] sidx;
  always_comb begin
    sel = ctrl_r[`LPM_CTRL_SEL];
    sidx = addr_in[9:2];
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !rd_in) begin
      rdata_out <= 32'h0;
    end else if (addr_in[11:10] == `LPM_A_STATS) begin
      if (addr_in[1:0] == 2'h0 && sidx[7:3] < NH && sidx[2:0] < NC)
        rdata_out <= {{(32-CW){1'b0}}, cnt_r[sel][sidx[7:3]][sidx[2:0]]};
      else rdata_out <= 32'h0;
    end else begin
      case (addr_in)
        `LPM_A_CTRL: rdata_out <= {30'h0, ctrl_r};
        `LPM_A_STATE: rdata_out <= {28'h0, outage_out, frame_loss_state_out};
        `LPM_A_QSTAT: rdata_out <= {20'h0, qst_r[sel][3], qst_r[sel][2],
                                    qst_r[sel][1], qst_r[sel][0]};
        `LPM_A_THRESH: rdata_out <= {16'h0, thresh_r};
        `LPM_A_SECS: rdata_out <= {20'h0, slot_r};
        default: rdata_out <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ovh_bandwidth_a: assert property (##1 ovh_kbps_out ==
    ($past(ctrl_r[`LPM_CTRL_PERF]) ? `LPM_OVH_KBPS : 8'h00))
    else $error("overhead bandwidth wrong");
  hour_wrap_a: assert property (hour_end |=> slot_r == 12'h000
    && cnt_r[0][0][0] == '0 && cnt_r[1][0][1] == '0)
    else $error("hour end did not restart current hour");
  hist_shift_a: assert property (hour_end && !clr_set[0] |=>
    cnt_r[0][NH-1][2] == $past(cnt_r[0][NH-2][2]))
    else $error("history did not shift");
  err_count_a: assert property (tick && !hour_end && !clr_set[0] &&
    (crc_seen_r[0] || crc_err_in[0]) |=> cnt_r[0][0][0] == $past(cnt_r[0][0][0]) + 1'b1)
    else $error("errored second not counted");
  sev_burst_a: assert property (tick && !hour_end && !clr_set[0] &&
    berr_now[0] != 16'h0 && !sev_now[0] |=>
    cnt_r[0][0][lpm_pkg::LPM_C_BURST] == $past(cnt_r[0][0][lpm_pkg::LPM_C_BURST]) + 1'b1
    && cnt_r[0][0][lpm_pkg::LPM_C_SEV] == $past(cnt_r[0][0][lpm_pkg::LPM_C_SEV]))
    else $error("bursty second miscounted");
  outage_enter_a: assert property (tick && av_r[0] == lpm_pkg::LPM_AVAIL &&
    sev_now[0] && run_r[0] == `LPM_UNAV_RUN - 4'h1 |=>
    outage_out[0] && av_r[0] == lpm_pkg::LPM_OUTAGE)
    else $error("outage not entered");
  outage_leave_a: assert property ($fell(outage_out[0]) |->
    $past(tick) && !$past(sev_now[0]) && $past(run_r[0]) == `LPM_UNAV_RUN - 4'h1)
    else $error("outage left early");
  floss_declare_a: assert property ($rose(frame_loss_state_out[0]) |->
    $past(bad[0]) && $past(floss_cnt_r[0]) == FLOSS_CYCLES - 1)
    else $error("frame loss declared at wrong time");
  floss_count_a: assert property (tick && !hour_end && !clr_set[0] &&
    flc_pend_r[0] |=> cnt_r[0][0][lpm_pkg::LPM_C_FLC] ==
    $past(cnt_r[0][0][lpm_pkg::LPM_C_FLC]) + 1'b1)
    else $error("frame loss declaration not counted");
  remote_absent_a: assert property (cnt_r[1][0][lpm_pkg::LPM_C_RDA] == '0)
    else $error("remote set counts data absence");
  clear_one_a: assert property (clr_set[1] && !tick |=>
    cnt_r[0][0][0] == $past(cnt_r[0][0][0]) && cnt_r[1][0][0] == '0)
    else $error("clear touched wrong set");

  outage_seen_c: cover property ($rose(outage_out[0]));
  floss_seen_c: cover property ($rose(frame_loss_state_out[0]));
  hour_seen_c: cover property (hour_end);
  clear_seen_c: cover property (clr_set[1] && tick);
endmodule // lpm_monitor

// [hdl/lpm_pkg.sv]
package lpm_pkg;
  typedef enum logic [2:0] {
    LPM_C_ERR, LPM_C_SEV, LPM_C_BURST, LPM_C_OUT, LPM_C_FLC, LPM_C_RDA
  } lpm_ctr_e;
  typedef enum logic {LPM_AVAIL, LPM_OUTAGE} lpm_av_e;
  typedef logic [2:0] lpm_qcode_t;
endpackage

// [tb/line_performance_monitor_tb.sv]
`timescale 1ns/1ns
`include "lpm_defines.svh"
module line_performance_monitor_tb;
  localparam int SEC = 20;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [11:0] addr_in = 12'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic crc_l = 1'b0;
  logic bit_l = 1'b0;
  logic sl_l = 1'b0;
  logic misframe_l = 1'b0;
  logic loopback_in = 1'b0;
  logic silent = 1'b0;
  logic err = 1'b0;
  logic crc_r, bit_r, rdat, sec_tick_out;
  logic [31:0] rdata_out, s;
  logic [7:0] ovh_kbps_out;
  logic [1:0] frame_loss_state_out, outage_out;
  int n_mismatch = 0;
  int n_checks = 0;

  always #10 clk_in = ~clk_in;

  lpm_monitor #(.SEC_CYCLES(SEC), .FLOSS_CYCLES(50), .FLCLR_CYCLES(20)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .crc_err_in({crc_r, crc_l}),
    .bit_err_in({bit_r, bit_l}), .sync_loss_in({sl_l, sl_l}),
    .out_of_framing_in({1'b0, misframe_l}), .loopback_in(loopback_in), .remote_data_in(rdat),
    .ovh_kbps_out(ovh_kbps_out), .frame_loss_state_out(frame_loss_state_out),
    .outage_out(outage_out), .sec_tick_out(sec_tick_out));

  lpm_far_end far (
    .clk_in(clk_in), .nrst_in(nrst_in), .perf_in(ovh_kbps_out != 8'h00),
    .silent_in(silent), .err_in(err), .data_out(rdat), .crc_err_out(crc_r),
    .bit_err_out(bit_r));

  // ==========================================
  // Access and checking tasks.
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand for one cycle only, so they are taken mid-way through that cycle.
  task rdv(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    v = rdata_out;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rdv(a, v);
    chk(v, exp);
  endtask

  function automatic logic [11:0] sa(input int h, input int c);
    return 12'h400 + 12'(h * 32 + c * 4);
  endfunction

  task st6(input int h, input int e0, input int e1, input int e2, input int e3,
      input int e4, input int e5);
    rd(sa(h, 0), 32'(e0));
    rd(sa(h, 1), 32'(e1));
    rd(sa(h, 2), 32'(e2));
    rd(sa(h, 3), 32'(e3));
    rd(sa(h, 4), 32'(e4));
    rd(sa(h, 5), 32'(e5));
  endtask

  // Returns one cycle after the second boundary; a missing tick ends the run.
  task tick;
    for (int i = 0; i < SEC + 4; i++) begin
      @(posedge clk_in);
      if (sec_tick_out === 1'b1) return;
    end
    n_mismatch++;
    print_verdict();
  endtask

  // One aligned second of local errors; callers align with tick first.
  task sec(input int nb, input logic c);
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_in);
      bit_l <= (i < nb);
      crc_l <= c && (i == 0);
    end
    @(posedge clk_in);
    bit_l <= 1'b0;
    tick();
  endtask

  // ==========================================
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(`LPM_A_CTRL, 32'h0);
    rd(`LPM_A_THRESH, 32'(`LPM_THR_RST));
    rd(`LPM_A_STATE, 32'h0);
    rd(12'h018, 32'h0);
    chk(32'(ovh_kbps_out), 32'h0);
    wr(`LPM_A_CTRL, 32'h1);
    @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(ovh_kbps_out), 32'(`LPM_OVH_KBPS));
    wr(`LPM_A_THRESH, 32'h4);
    rdv(`LPM_A_SECS, s);
    tick();
    rd(`LPM_A_SECS, s + 32'h1);
    @(posedge clk_in);
    silent <= 1'b1;
    tick();
    wr(`LPM_A_CLEAR, 32'h1);
    repeat (3) tick();
    silent <= 1'b0;
    rd(sa(0, 5), 32'h3);
    @(posedge clk_in);
    loopback_in <= 1'b1;
    tick();
    loopback_in <= 1'b0;
    rd(`LPM_A_QSTAT, 32'h1 << `LPM_QS_T);
    @(posedge clk_in);
    sl_l <= 1'b1;
    repeat (46) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(frame_loss_state_out), 32'h0);
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(frame_loss_state_out), 32'h3);
    @(posedge clk_in);
    sl_l <= 1'b0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(frame_loss_state_out), 32'h3);
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(frame_loss_state_out), 32'h0);
    rd(`LPM_A_QSTAT, 32'h6);
    @(posedge clk_in);
    misframe_l <= 1'b1;
    repeat (40) @(posedge clk_in);
    misframe_l <= 1'b0;
    @(posedge clk_in);
    misframe_l <= 1'b1;
    repeat (40) @(posedge clk_in);
    @(negedge clk_in);
    chk(32'(frame_loss_state_out), 32'h0);
    repeat (15) @(posedge clk_in);
    misframe_l <= 1'b0;
    repeat (25) @(posedge clk_in);
    tick();
    sec(4, 1'b1);
    for (int k = 0; k < 10; k++) begin
      sec(5, 1'b0);
      @(negedge clk_in);
      chk(32'(outage_out), 32'(k == 9));
    end
    for (int k = 0; k < 10; k++) begin
      sec(0, 1'b0);
      @(negedge clk_in);
      chk(32'(outage_out), 32'(k != 9));
    end
    st6(0, 1, 10, 1, 10, 2, 3);
    rd(`LPM_A_QSTAT, 32'h7);
    wr(`LPM_A_CTRL, 32'h3);
    wr(`LPM_A_CLEAR, 32'h1);
    tick();
    err <= 1'b1;
    tick();
    repeat (15) @(posedge clk_in);
    err <= 1'b0;
    tick();
    st6(0, 2, 2, 0, 0, 0, 0);
    wr(`LPM_A_CLEAR, 32'h1);
    rd(sa(0, 0), 32'h0);
    wr(`LPM_A_CTRL, 32'h2);
    tick();
    err <= 1'b1;
    tick();
    err <= 1'b0;
    tick();
    rd(sa(0, 0), 32'h0);
    wr(`LPM_A_CTRL, 32'h1);
    rd(sa(0, 0), 32'h1);
    wr(`LPM_A_CLEAR, 32'h1);
    tick();
    sec(4, 1'b1);
    // The hour boundary is about 72000 cycles away; each pass reads the slot index once.
    for (int i = 0; i < 3700; i++) begin
      rdv(`LPM_A_SECS, s);
      if (s === 32'h0) break;
      tick();
    end
    chk(s, 32'h0);
    rd(sa(1, 0), 32'h1);
    rd(sa(1, 2), 32'h1);
    rd(sa(0, 0), 32'h0);
    rd(sa(25, 0), 32'h0);
    print_verdict();
  end
endmodule // line_performance_monitor_tb

// [tb/lpm_far_end.sv]
`timescale 1ns/1ns
// ==========================================
// Far end card model.
module lpm_far_end (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic perf_in,
  input wire logic silent_in,
  input wire logic err_in,
  output logic data_out,
  output logic crc_err_out,
  output logic bit_err_out
);
  logic [2:0] ph_r;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end

  // Remote error reports ride on the overhead, so they vanish unless the local end also monitors.
  always_comb begin
    data_out = !silent_in && (ph_r == 3'h0);
    crc_err_out = perf_in && err_in && (ph_r == 3'h1);
    bit_err_out = perf_in && err_in && ph_r[0];
  end
endmodule // lpm_far_end
